// ---- hdl/irq_flags_reset_status_pc_load.sv ----
// Purpose: peripheral request flags, power-control reset cause and program counter load
// Assumes: APB slave, 50 MHz clock_i, event inputs are one-cycle pulses on clock_i
// Notes: comparator outputs are asynchronous and pass a three-stage synchroniser
module irq_flags_reset_status_pc_load
  import flags_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic serial_start_i,
  input wire logic serial_stop_i,
  input wire logic serial_idle_i,
  input wire logic [1:0] capcmp_one_mode_i,
  input wire logic capcmp_one_capture_i,
  input wire logic capcmp_one_match_i,
  input wire logic [1:0] capcmp_two_mode_i,
  input wire logic capcmp_two_capture_i,
  input wire logic capcmp_two_match_i,
  input wire logic timer_two_period_match_i,
  input wire logic timer_one_count_overflow_i,
  input wire logic osc_fail_switched_i,
  input wire logic comparator_a_output_i,
  input wire logic comparator_b_output_i,
  input wire logic nv_write_done_i,
  input wire logic bus_collision_i,
  input wire logic low_power_wake_i,
  input wire logic reset_cause_power_on_i,
  input wire logic reset_cause_brownout_i,
  input wire logic [1:0] brownout_mode_field_i,
  input wire logic pc_advance_i,
  input wire logic pc_jump_i,
  input wire logic [10:0] pc_jump_target_i,
  output logic [3:0] flags_one_o,
  output logic [7:0] flags_two_o,
  output logic low_power_wake_enable_o,
  output logic brownout_detect_enable_o,
  output logic [12:0] program_counter_o
);

  // comparator change detectors
  level_change_if cmp_a_link ();
  level_change_if cmp_b_link ();

  assign cmp_a_link.level_raw = comparator_a_output_i;
  assign cmp_b_link.level_raw = comparator_b_output_i;

  level_change_detect u_cmp_a (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .link(cmp_a_link)
  );

  level_change_detect u_cmp_b (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .link(cmp_b_link)
  );

  // state
  logic [3:0] flags_one_r;
  logic [3:0] flags_one_nxt;
  logic [7:0] flags_two_r;
  logic [7:0] flags_two_nxt;
  logic wake_enable_r;
  logic soft_brownout_r;
  logic power_on_status_r;
  logic brownout_status_r;
  logic brownout_detect_r;
  logic [PC_WIDTH-1:0] pc_r;
  logic [PC_WIDTH-1:0] pc_nxt;
  logic [LATCH_WIDTH-1:0] latch_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  // bus decode
  wire access_w = psel_i & penable_i;
  wire answer_now_w = access_w & ~pready_r;
  wire commit_w = access_w & pready_r;
  wire write_commit_w = commit_w & pwrite_i;

  wire hit_flags_one_w = (paddr_i == OFF_FLAGS_ONE);
  wire hit_flags_two_w = (paddr_i == OFF_FLAGS_TWO);
  wire hit_power_w = (paddr_i == OFF_POWER_CTRL);
  wire hit_pc_low_w = (paddr_i == OFF_PC_LOW);
  wire hit_latch_w = (paddr_i == OFF_PC_LATCH);
  wire hit_pc_status_w = (paddr_i == OFF_PC_STATUS);
  wire hit_any_w = hit_flags_one_w | hit_flags_two_w | hit_power_w |
                   hit_pc_low_w | hit_latch_w | hit_pc_status_w;

  wire wr_flags_one_w = write_commit_w & hit_flags_one_w;
  wire wr_flags_two_w = write_commit_w & hit_flags_two_w;
  wire wr_power_w = write_commit_w & hit_power_w;
  wire wr_pc_low_w = write_commit_w & hit_pc_low_w;
  wire wr_latch_w = write_commit_w & hit_latch_w;

  // read views; unimplemented bits read zero
  wire [7:0] power_view_w = {2'b00,
                             wake_enable_r,
                             soft_brownout_r,
                             2'b00,
                             power_on_status_r,
                             brownout_status_r};
  wire [31:0] rd_data_w =
    hit_flags_one_w ? {28'h0000000, flags_one_r} :
    hit_flags_two_w ? {24'h000000, flags_two_r} :
    hit_power_w ? {24'h000000, power_view_w} :
    hit_pc_low_w ? {24'h000000, pc_r[PC_LOW_WIDTH-1:0]} :
    hit_latch_w ? {27'h0000000, latch_r} :
    hit_pc_status_w ? {19'h00000, pc_r} :
    32'h00000000;

  // hardware set conditions, independent of any enable bit
  wire capcmp_one_set_w =
    ((capcmp_one_mode_i == CAPCMP_MODE_CAPTURE) & capcmp_one_capture_i) |
    ((capcmp_one_mode_i == CAPCMP_MODE_COMPARE) & capcmp_one_match_i);
  wire capcmp_two_set_w =
    ((capcmp_two_mode_i == CAPCMP_MODE_CAPTURE) & capcmp_two_capture_i) |
    ((capcmp_two_mode_i == CAPCMP_MODE_COMPARE) & capcmp_two_match_i);
  wire serial_set_w = serial_idle_i & (serial_start_i | serial_stop_i);

  logic [3:0] set_one_w;
  logic [7:0] set_two_w;

  assign set_one_w[BIT_TIMER_ONE] = timer_one_count_overflow_i;
  assign set_one_w[BIT_TIMER_TWO] = timer_two_period_match_i;
  assign set_one_w[BIT_CAPCMP_ONE] = capcmp_one_set_w;
  assign set_one_w[BIT_SERIAL] = serial_set_w;

  assign set_two_w[BIT_CAPCMP_TWO] = capcmp_two_set_w;
  assign set_two_w[1] = 1'b0;
  assign set_two_w[BIT_LOW_POWER_WAKE] = low_power_wake_i;
  assign set_two_w[BIT_BUS_COLLISION] = bus_collision_i;
  assign set_two_w[BIT_NV_WRITE_DONE] = nv_write_done_i;
  assign set_two_w[BIT_COMPARATOR_A] = cmp_a_link.changed;
  assign set_two_w[BIT_COMPARATOR_B] = cmp_b_link.changed;
  assign set_two_w[BIT_OSC_FAIL] = osc_fail_switched_i;

  // per-bit next values: set beats a software clear
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag_bits
      if (gi < 4) begin : g_one
        assign flags_one_nxt[gi] = FLAGS_ONE_IMPL[gi] &
          (set_one_w[gi] | (wr_flags_one_w ? pwdata_i[gi] : flags_one_r[gi]));
      end
      assign flags_two_nxt[gi] = FLAGS_TWO_IMPL[gi] &
        (set_two_w[gi] | (wr_flags_two_w ? pwdata_i[gi] : flags_two_r[gi]));
    end
  endgenerate

  // program counter next value; a bus write to the low byte wins over the core
  wire [PC_WIDTH-1:0] pc_from_low_w = {latch_r, pwdata_i[PC_LOW_WIDTH-1:0]};
  wire [PC_WIDTH-1:0] pc_from_jump_w = {latch_r[4:3], pc_jump_target_i};
  wire [PC_WIDTH-1:0] pc_plus_one_w = PC_WIDTH'(pc_r + 13'h0001);

  always_comb begin
    pc_nxt = pc_r;
    if (wr_pc_low_w) begin
      pc_nxt = pc_from_low_w;
    end else if (pc_jump_i) begin
      pc_nxt = pc_from_jump_w;
    end else if (pc_advance_i) begin
      pc_nxt = pc_plus_one_w;
    end
  end

  // brown-out detector enable from config mode field
  wire brownout_detect_nxt_w =
    (brownout_mode_field_i == BROWNOUT_MODE_SOFT) ? soft_brownout_r :
    (brownout_mode_field_i != BROWNOUT_MODE_OFF);

  // flag registers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      flags_one_r <= FLAGS_ONE_RESET;
      flags_two_r <= FLAGS_TWO_RESET;
    end else if (ce_i) begin
      flags_one_r <= flags_one_nxt;
      flags_two_r <= flags_two_nxt;
    end
  end

  // power control; reset cause decides which status bits fall
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wake_enable_r <= WAKE_ENABLE_RESET;
      soft_brownout_r <= SOFT_BROWNOUT_RESET;
      if (reset_cause_power_on_i) begin
        power_on_status_r <= 1'b0;
      end
      if (reset_cause_power_on_i | reset_cause_brownout_i) begin
        brownout_status_r <= 1'b0;
      end
    end else if (ce_i && wr_power_w) begin
      wake_enable_r <= pwdata_i[BIT_WAKE_ENABLE];
      soft_brownout_r <= pwdata_i[BIT_SOFT_BROWNOUT];
      power_on_status_r <= pwdata_i[BIT_POWER_ON_STATUS];
      brownout_status_r <= pwdata_i[BIT_BROWNOUT_STATUS];
    end
  end

  // output copy of the brown-out enable
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      brownout_detect_r <= 1'b0;
    end else if (ce_i) begin
      brownout_detect_r <= brownout_detect_nxt_w;
    end
  end

  // program counter and its latch
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pc_r <= PC_RESET;
      latch_r <= LATCH_RESET;
    end else if (ce_i) begin
      pc_r <= pc_nxt;
      if (wr_latch_w) begin
        latch_r <= pwdata_i[LATCH_WIDTH-1:0];
      end
    end
  end

  // apb answer: one wait state, data and error valid with pready
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else if (ce_i) begin
      pready_r <= answer_now_w;
      pslverr_r <= answer_now_w & ~hit_any_w;
      prdata_r <= (answer_now_w & ~pwrite_i) ? rd_data_w : 32'h00000000;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign flags_one_o = flags_one_r;
  assign flags_two_o = flags_two_r;
  assign low_power_wake_enable_o = wake_enable_r;
  assign brownout_detect_enable_o = brownout_detect_r;
  assign program_counter_o = pc_r;

endmodule

// ---- hdl/flags_pkg.sv ----
// Purpose: constants shared by the flag, power-control and program counter block
// Assumes: 32-bit APB data, byte addresses, one aligned word per register
// Notes: flag vectors keep their documented bit positions
package flags_pkg;

  localparam logic [7:0] OFF_FLAGS_ONE = 8'h00;
  localparam logic [7:0] OFF_FLAGS_TWO = 8'h04;
  localparam logic [7:0] OFF_POWER_CTRL = 8'h08;
  localparam logic [7:0] OFF_PC_LOW = 8'h0C;
  localparam logic [7:0] OFF_PC_LATCH = 8'h10;
  localparam logic [7:0] OFF_PC_STATUS = 8'h14;

  localparam int PC_WIDTH = 13;
  localparam int PC_LOW_WIDTH = 8;
  localparam int LATCH_WIDTH = 5;
  localparam int JUMP_WIDTH = 11;

  localparam logic [3:0] FLAGS_ONE_IMPL = 4'hF;
  localparam logic [7:0] FLAGS_TWO_IMPL = 8'hFD;
  localparam logic [3:0] FLAGS_ONE_RESET = 4'h0;
  localparam logic [7:0] FLAGS_TWO_RESET = 8'h00;

  localparam int BIT_TIMER_ONE = 0;
  localparam int BIT_TIMER_TWO = 1;
  localparam int BIT_CAPCMP_ONE = 2;
  localparam int BIT_SERIAL = 3;

  localparam int BIT_CAPCMP_TWO = 0;
  localparam int BIT_LOW_POWER_WAKE = 2;
  localparam int BIT_BUS_COLLISION = 3;
  localparam int BIT_NV_WRITE_DONE = 4;
  localparam int BIT_COMPARATOR_A = 5;
  localparam int BIT_COMPARATOR_B = 6;
  localparam int BIT_OSC_FAIL = 7;

  localparam int BIT_WAKE_ENABLE = 5;
  localparam int BIT_SOFT_BROWNOUT = 4;
  localparam int BIT_POWER_ON_STATUS = 1;
  localparam int BIT_BROWNOUT_STATUS = 0;

  localparam logic WAKE_ENABLE_RESET = 1'b0;
  localparam logic SOFT_BROWNOUT_RESET = 1'b1;
  localparam logic [PC_WIDTH-1:0] PC_RESET = 13'h0000;
  localparam logic [LATCH_WIDTH-1:0] LATCH_RESET = 5'h00;

  localparam logic [1:0] CAPCMP_MODE_CAPTURE = 2'h0;
  localparam logic [1:0] CAPCMP_MODE_COMPARE = 2'h1;
  localparam logic [1:0] CAPCMP_MODE_PWM = 2'h2;

  localparam logic [1:0] BROWNOUT_MODE_OFF = 2'h0;
  localparam logic [1:0] BROWNOUT_MODE_SOFT = 2'h1;

endpackage

// ---- hdl/level_change_if.sv ----
// Purpose: carries one raw level into a change detector and its results back
// Assumes: raw level may come from outside the clock domain
// Notes: changed is a one-cycle pulse
interface level_change_if;
  logic level_raw;
  logic level;
  logic changed;

  modport detector (
    input level_raw,
    output level,
    output changed
  );

  modport user (
    output level_raw,
    input level,
    input changed
  );
endinterface

// ---- hdl/level_change_detect.sv ----
// Purpose: three-stage synchroniser that reports a settled change of a level
// Assumes: synchronous active-high reset, clock enable freezes state
// Notes: first settled level after reset is taken without a change pulse
module level_change_detect
  import flags_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic ce_i,
  level_change_if.detector link
);

  logic sync_a_r;
  logic sync_b_r;
  logic sync_c_r;
  logic settled_r;
  logic primed_r;
  logic changed_r;

  wire agree_w = (sync_b_r == sync_c_r);
  wire differ_w = agree_w & (sync_c_r != settled_r);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      // chain keeps sampling in reset: a pin held high gives no false change
      sync_a_r <= link.level_raw;
      sync_b_r <= sync_a_r;
      sync_c_r <= sync_b_r;
      settled_r <= 1'b0;
      primed_r <= 1'b0;
      changed_r <= 1'b0;
    end else if (ce_i) begin
      sync_a_r <= link.level_raw;
      sync_b_r <= sync_a_r;
      sync_c_r <= sync_b_r;
      if (agree_w) begin
        settled_r <= sync_c_r;
        primed_r <= 1'b1;
      end
      changed_r <= differ_w & primed_r;
    end
  end

  assign link.level = settled_r;
  assign link.changed = changed_r;

endmodule

// ---- verification/irq_flags_properties.sv ----
// Purpose: timing checks on bus answer, flag setting and pc loading
// Assumes: one clock domain, synchronous active-high reset
// Notes: watches top-level ports only
module irq_flags_properties
  import flags_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic timer_one_count_overflow_i,
  input wire logic low_power_wake_i,
  input wire logic pc_advance_i,
  input wire logic pc_jump_i,
  input wire logic [1:0] brownout_mode_field_i,
  input wire logic [3:0] flags_one_o,
  input wire logic [7:0] flags_two_o,
  input wire logic brownout_detect_enable_o,
  input wire logic [12:0] program_counter_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // write accepted at this edge
  wire acc = psel_i & penable_i & pready_o & pwrite_i;

  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  a_access_answer: assert property (psel_i && penable_i && !pready_o && ce_i |=> pready_o)
    else $error("access phase not answered next cycle");
  a_error_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error response without ready");
  a_overflow_sets: assert property (timer_one_count_overflow_i && ce_i |=> flags_one_o[0])
    else $error("overflow did not set its flag");
  a_wake_sets: assert property (low_power_wake_i && ce_i |=> flags_two_o[2])
    else $error("wake event did not set its flag");
  a_bit_one_zero: assert property (flags_two_o[1] == 1'b0)
    else $error("unimplemented flag bit is set");
  a_match_held: assert property (flags_one_o[1] && !(acc && paddr_i == OFF_FLAGS_ONE)
    |=> flags_one_o[1])
    else $error("period match flag lost without a write");
  a_pc_low_load: assert property (acc && ce_i && paddr_i == OFF_PC_LOW
    |=> program_counter_o[7:0] == $past(pwdata_i[7:0]))
    else $error("pc low byte not loaded by write");
  a_pc_advance: assert property (pc_advance_i && !pc_jump_i && ce_i
    && !(acc && paddr_i == OFF_PC_LOW)
    |=> program_counter_o == $past(program_counter_o) + 13'h0001)
    else $error("pc did not advance by one");
  a_bor_mode_off: assert property (brownout_mode_field_i == BROWNOUT_MODE_OFF && ce_i
    |=> !brownout_detect_enable_o)
    else $error("brown-out detect on in off mode");
  a_pc_reset_clear: assert property (@(posedge clock_i) disable iff (1'b0)
    srst_i |=> program_counter_o == 13'h0000)
    else $error("reset did not clear pc");
endmodule

bind irq_flags_reset_status_pc_load irq_flags_properties i_irq_flags_properties (
  .clock_i, .srst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .pready_o, .pslverr_o, .timer_one_count_overflow_i, .low_power_wake_i, .pc_advance_i,
  .pc_jump_i, .brownout_mode_field_i, .flags_one_o, .flags_two_o,
  .brownout_detect_enable_o, .program_counter_o);

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for flags, power control and pc load
// Assumes: every bus answer comes within a bounded wait
// Notes: bus results compared by a monitor against a queue of notes
module tb_top
  import flags_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] EVM = 12'h9CB;
  logic clock_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, pready_o, pslverr_o, lpw, bde;
  logic [7:0] paddr_i = 8'h00, f2, ev2 = 8'h00, lo;
  logic [31:0] pwdata_i = 32'h0, prdata_o, d;
  logic [3:0] f1, ev1 = 4'h0;
  logic [1:0] cmode = 2'h0, bmode = 2'h0;
  logic cap = 1'b0, mt = 1'b0, cmpa = 1'b0, cmpb = 1'b0, cpor = 1'b1, cbor = 1'b0;
  logic adv = 1'b0, jmp = 1'b0, idle = 1'b1, stp = 1'b0;
  logic [10:0] tgt = 11'h0;
  logic [12:0] pc, pe;
  logic [11:0] ex = 12'h0;
  logic [4:0] lat;
  logic [32:0] exp_q[$];
  int errors = 0, checked = 0, seed = 78368;

  irq_flags_reset_status_pc_load i_irq_flags_reset_status_pc_load (
    .clock_i, .srst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .serial_start_i(ev1[3]), .serial_stop_i(stp),
    .serial_idle_i(idle), .capcmp_one_mode_i(cmode), .capcmp_one_capture_i(cap),
    .capcmp_one_match_i(mt), .capcmp_two_mode_i(cmode), .capcmp_two_capture_i(cap),
    .capcmp_two_match_i(mt), .timer_two_period_match_i(ev1[1]),
    .timer_one_count_overflow_i(ev1[0]), .osc_fail_switched_i(ev2[7]),
    .comparator_a_output_i(cmpa), .comparator_b_output_i(cmpb), .nv_write_done_i(ev2[4]),
    .bus_collision_i(ev2[3]), .low_power_wake_i(ev2[2]), .reset_cause_power_on_i(cpor),
    .reset_cause_brownout_i(cbor), .brownout_mode_field_i(bmode), .pc_advance_i(adv),
    .pc_jump_i(jmp), .pc_jump_target_i(tgt), .flags_one_o(f1), .flags_two_o(f2),
    .low_power_wake_enable_o(lpw), .brownout_detect_enable_o(bde), .program_counter_o(pc));

  initial begin
    forever #10 clock_i = ~clock_i;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input string n, input logic [32:0] s, input logic [32:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
                     input logic [32:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= v;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      complete_run();
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wait_f2(input int b);
    int n;
    n = 0;
    while (f2[b] !== 1'b1 && n < 12) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 12) begin
      errors++;
      complete_run();
    end
  endtask

  // bus monitor: every answer matched against the oldest note
  always @(posedge clock_i) begin
    if (pready_o === 1'b1) check("bus", {pslverr_o, prdata_o}, exp_q.pop_front());
  end

  initial begin
    tick(4);
    srst_i <= 1'b0;
    cpor <= 1'b0;
    apb(0, OFF_POWER_CTRL, 32'h0, 33'h10);
    apb(0, OFF_FLAGS_TWO, 32'h0, 33'h0);
    apb(0, OFF_PC_STATUS, 32'h0, 33'h0);
    apb(1, 8'h18, 32'hFFFF_FFFF, 33'h1_0000_0000);
    apb(0, 8'h40, 32'h0, 33'h1_0000_0000);
    $display("reset and map test done");
    for (int k = 0; k < 12; k++) begin
      if (EVM[k]) begin
        {ev2, ev1} <= 12'h001 << k;
        tick(1);
        {ev2, ev1} <= 12'h000;
        tick(1);
        ex = ex | (12'h001 << k);
        check("flags", {21'h0, f2, f1}, {21'h0, ex});
      end
    end
    apb(1, OFF_FLAGS_ONE, 32'h0, 33'h0);
    apb(1, OFF_FLAGS_TWO, 32'h0, 33'h0);
    apb(0, OFF_FLAGS_TWO, 32'h0, 33'h0);
    $display("event flag test done");
    for (int m = 0; m < 4; m++) begin
      cmode <= m[1:0];
      cap <= (m != 1);
      mt <= (m != 0);
      tick(1);
      cap <= 1'b0;
      mt <= 1'b0;
      tick(1);
      check("capcmp", {31'h0, f2[0], f1[2]}, {31'h0, {2{m < 2}}});
      apb(1, OFF_FLAGS_ONE, 32'h0, 33'h0);
      apb(1, OFF_FLAGS_TWO, 32'h0, 33'h0);
    end
    fork
      apb(1, OFF_FLAGS_ONE, 32'h0, 33'h0);
      begin
        tick(3);
        ev1 <= 4'h1;
        tick(1);
        ev1 <= 4'h0;
      end
    join
    tick(1);
    check("set wins", {29'h0, f1}, 33'h1);
    ce_i <= 1'b0;
    ev1 <= 4'h2;
    tick(1);
    ce_i <= 1'b1;
    idle <= 1'b0;
    ev1 <= 4'h8;
    tick(1);
    check("clock enable", {29'h0, f1}, 33'h1);
    idle <= 1'b1;
    ev1 <= 4'h0;
    stp <= 1'b1;
    tick(1);
    check("serial busy", {29'h0, f1}, 33'h1);
    stp <= 1'b0;
    tick(1);
    check("serial stop", {29'h0, f1}, 33'h9);
    cmpa <= 1'b1;
    wait_f2(5);
    cmpb <= 1'b1;
    wait_f2(6);
    apb(0, OFF_FLAGS_TWO, 32'h0, 33'h60);
    $display("mode and comparator test done");
    for (int i = 0; i < 3; i++) begin
      lat = 5'($random(seed));
      lo = 8'($random(seed));
      tgt <= 11'($random(seed));
      apb(1, OFF_PC_LATCH, {27'h0, lat}, 33'h0);
      apb(1, OFF_PC_LOW, {24'h0, lo}, 33'h0);
      tick(1);
      check("pc write", {20'h0, pc}, {20'h0, lat, lo});
      jmp <= 1'b1;
      tick(1);
      jmp <= 1'b0;
      tick(1);
      pe = {lat[4:3], tgt};
      check("pc jump", {20'h0, pc}, {20'h0, pe});
      adv <= 1'b1;
      tick(1);
      adv <= 1'b0;
      tick(1);
      pe = pe + 13'h0001;
      apb(0, OFF_PC_LOW, 32'h0, {25'h0, pe[7:0]});
      apb(0, OFF_PC_STATUS, 32'h0, {20'h0, pe});
    end
    $display("pc load test done");
    for (int m = 0; m < 4; m++) begin
      bmode <= m[1:0];
      d = $random(seed);
      apb(1, OFF_POWER_CTRL, d, 33'h0);
      apb(0, OFF_POWER_CTRL, 32'h0, {1'b0, d & 32'h33});
      check("brownout enable", {32'h0, bde}, {32'h0, m == 1 ? d[4] : m != 0});
      check("wake enable", {32'h0, lpw}, {32'h0, d[5]});
    end
    apb(1, OFF_POWER_CTRL, 32'h3, 33'h0);
    srst_i <= 1'b1;
    cbor <= 1'b1;
    tick(4);
    srst_i <= 1'b0;
    cbor <= 1'b0;
    check("pc reset", {20'h0, pc}, 33'h0);
    apb(0, OFF_POWER_CTRL, 32'h0, 33'h12);
    apb(0, OFF_FLAGS_TWO, 32'h0, 33'h0);
    $display("power control test done");
    complete_run();
  end
endmodule
